// ===== pin_share.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`default_nettype none
// Operation
// [R1] hold pins are port bits unless hold selected
// [R2] hold request sampled in bus mode or hold
// [R3] hold acknowledge driven in bus mode or hold
// [R4] ready pin is port bit unless ready selected
// [R5] ready input needs bus mode and ready enable
// [R6] clock pin is port bit unless clock selected
// [R7] bus clock driven in bus mode when enabled
// [R8] receive pin always port bit, also receive data
// [R9] others must not drive receive pin while receiving
// [R10] transmit pin is port bit while transmit off
// [R11] transmit enabled drives transmit data on pin
// [R12] selection decoded from settings, one driver per pin
module pin_share (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [pin_share_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pin_share_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [pin_share_pkg::DATA_W-1:0] rdata_o,
  input wire pin_share_pkg::pins_t pin_in_i,
  output pin_share_pkg::pins_t pin_out_o,
  output pin_share_pkg::pins_t pin_oe_o,
  input wire logic hold_acknowledge_out_i,
  output logic hold_request_in_o,
  output logic ext_ready_o,
  input wire logic serial_port_zero_tx_data_i,
  output logic serial_port_zero_rx_data_o,
  output logic ext_bus_mode_o
);

  // ==========================================================
  // function decode
  // one place decides which function owns each pin, so the
  // pin drivers and the read-back can never disagree
  // [R12] selection from settings
  function automatic pin_share_pkg::sel_s sel_of(input pin_share_pkg::ctrl_s c);
    pin_share_pkg::sel_s s;
    // [R2] hold in bus mode
    s.hold = c.ext_bus | c.hold_en;
    // [R5] ready needs bus
    s.ready = c.ext_bus & c.ready_en;
    // [R7] clock needs bus mode and enable high
    s.clk = c.ext_bus & c.clk_en;
    // [R11] transmit owns pin
    s.tx = c.tx_en;
    return s;
  endfunction

  // dedicated value when selected, else the port latch
  function automatic logic pick(input logic sel, input logic ded, input logic gpio);
    return sel ? ded : gpio;
  endfunction

  // ==========================================================
  // state
  logic [pin_share_pkg::DATA_W-1:0] mode_reg;
  logic [pin_share_pkg::DATA_W-1:0] func_reg;
  pin_share_pkg::pins_t port_out;
  pin_share_pkg::pins_t port_dir;
  pin_share_pkg::pins_t pin_sync;
  logic bus_clk;
  pin_share_pkg::ctrl_s ctrl;
  pin_share_pkg::sel_s sel;
  pin_share_pkg::pins_t next_pin_out;
  pin_share_pkg::pins_t next_pin_oe;
  logic [pin_share_pkg::DATA_W-1:0] next_rdata;
  logic [pin_share_pkg::DATA_W-1:0] sel_word;

  // ==========================================================
  // pin input synchroniser
  pin_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_in_i),
    .sync_o(pin_sync)
  );

  // ==========================================================
  // settings gathered into one struct
  always_comb begin
    ctrl.ext_bus = mode_reg[pin_share_pkg::MODE_EXT_BUS_BIT];
    ctrl.hold_en = func_reg[pin_share_pkg::FUNC_HOLD_BIT];
    ctrl.ready_en = func_reg[pin_share_pkg::FUNC_READY_BIT];
    ctrl.clk_en = func_reg[pin_share_pkg::FUNC_CLK_BIT];
    ctrl.tx_en = func_reg[pin_share_pkg::FUNC_TX_BIT];
    sel = sel_of(ctrl);
  end

  // selection word for read-back
  always_comb begin
    sel_word = '0;
    sel_word[pin_share_pkg::SEL_HOLD_BIT] = sel.hold;
    sel_word[pin_share_pkg::SEL_READY_BIT] = sel.ready;
    sel_word[pin_share_pkg::SEL_CLK_BIT] = sel.clk;
    sel_word[pin_share_pkg::SEL_TX_BIT] = sel.tx;
  end

  // ==========================================================
  // register writes
  // mode register, bus mode against single-chip
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= pin_share_pkg::MODE_RST;
    end else if (wr_i && addr_i == pin_share_pkg::REG_MODE) begin
      mode_reg <= wdata_i & 8'h01;
    end
  end

  // function enable register, unused bits stay zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      func_reg <= pin_share_pkg::FUNC_RST;
    end else if (wr_i && addr_i == pin_share_pkg::REG_FUNC) begin
      func_reg <= wdata_i & 8'h0F;
    end
  end

  // port output latch, kept even while a pin is dedicated
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_out <= pin_share_pkg::PORT_OUT_RST;
    end else if (wr_i && addr_i == pin_share_pkg::REG_PORT_OUT) begin
      port_out <= wdata_i[pin_share_pkg::PIN_N-1:0];
    end
  end

  // port direction, one means output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_dir <= pin_share_pkg::PORT_DIR_RST;
    end else if (wr_i && addr_i == pin_share_pkg::REG_PORT_DIR) begin
      port_dir <= wdata_i[pin_share_pkg::PIN_N-1:0];
    end
  end

  // ==========================================================
  // register reads
  // unmapped offsets answer zero
  always_comb begin
    next_rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        pin_share_pkg::REG_MODE: begin
          next_rdata = mode_reg;
        end
        pin_share_pkg::REG_FUNC: begin
          next_rdata = func_reg;
        end
        pin_share_pkg::REG_PORT_OUT: begin
          next_rdata = {2'h0, port_out};
        end
        pin_share_pkg::REG_PORT_DIR: begin
          next_rdata = {2'h0, port_dir};
        end
        pin_share_pkg::REG_PORT_IN: begin
          next_rdata = {2'h0, pin_sync};
        end
        pin_share_pkg::REG_SEL: begin
          next_rdata = sel_word;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= pin_share_pkg::RDATA_RST;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // bus clock
  // half the core clock; runs only while the pin carries it
  // so the idle pin does not toggle needlessly
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_clk <= 1'b0;
    end else if (sel.clk) begin
      bus_clk <= ~bus_clk;
    end else begin
      bus_clk <= 1'b0;
    end
  end

  // ==========================================================
  // pin drive decode
  always_comb begin
    next_pin_out = port_out;
    next_pin_oe = port_dir;
    // [R1] hold request pin released
    next_pin_out[pin_share_pkg::PIN_P3B4] =
      pick(sel.hold, 1'b0, port_out[pin_share_pkg::PIN_P3B4]);
    next_pin_oe[pin_share_pkg::PIN_P3B4] =
      pick(sel.hold, 1'b0, port_dir[pin_share_pkg::PIN_P3B4]);
    // [R3] hold acknowledge drive
    next_pin_out[pin_share_pkg::PIN_P3B5] =
      pick(sel.hold, hold_acknowledge_out_i, port_out[pin_share_pkg::PIN_P3B5]);
    next_pin_oe[pin_share_pkg::PIN_P3B5] =
      pick(sel.hold, 1'b1, port_dir[pin_share_pkg::PIN_P3B5]);
    // [R4] ready pin input
    next_pin_out[pin_share_pkg::PIN_P3B6] =
      pick(sel.ready, 1'b0, port_out[pin_share_pkg::PIN_P3B6]);
    next_pin_oe[pin_share_pkg::PIN_P3B6] =
      pick(sel.ready, 1'b0, port_dir[pin_share_pkg::PIN_P3B6]);
    // [R6] [R7] bus clock out
    next_pin_out[pin_share_pkg::PIN_P3B7] =
      pick(sel.clk, bus_clk, port_out[pin_share_pkg::PIN_P3B7]);
    next_pin_oe[pin_share_pkg::PIN_P3B7] =
      pick(sel.clk, 1'b1, port_dir[pin_share_pkg::PIN_P3B7]);
    // [R8] receive pin plain port
    next_pin_out[pin_share_pkg::PIN_P4B0] = port_out[pin_share_pkg::PIN_P4B0];
    next_pin_oe[pin_share_pkg::PIN_P4B0] = port_dir[pin_share_pkg::PIN_P4B0];
    // [R10] [R11] transmit override
    next_pin_out[pin_share_pkg::PIN_P4B1] =
      pick(sel.tx, serial_port_zero_tx_data_i, port_out[pin_share_pkg::PIN_P4B1]);
    next_pin_oe[pin_share_pkg::PIN_P4B1] =
      pick(sel.tx, 1'b1, port_dir[pin_share_pkg::PIN_P4B1]);
  end

  // pins released during reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o <= pin_share_pkg::PORT_OUT_RST;
      pin_oe_o <= pin_share_pkg::PORT_DIR_RST;
    end else begin
      pin_out_o <= next_pin_out;
      pin_oe_o <= next_pin_oe;
    end
  end

  // ==========================================================
  // inputs toward the core
  // [R2] hold request sampled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_request_in_o <= 1'b0;
    end else begin
      hold_request_in_o <= sel.hold & pin_sync[pin_share_pkg::PIN_P3B4];
    end
  end

  // [R5] ready forced high otherwise
  // a deselected pin must never stretch a bus cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_ready_o <= 1'b1;
    end else begin
      ext_ready_o <= ~sel.ready | pin_sync[pin_share_pkg::PIN_P3B6];
    end
  end

  // [R8] receiver always sees pin
  // with the port driving it too, the receiver hears its own
  // output; software must keep the direction low while receiving
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_port_zero_rx_data_o <= 1'b1;
    end else begin
      serial_port_zero_rx_data_o <= pin_sync[pin_share_pkg::PIN_P4B0];
    end
  end

  // bus mode copy for the bus controller
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_bus_mode_o <= 1'b0;
    end else begin
      ext_bus_mode_o <= ctrl.ext_bus;
    end
  end

endmodule
`default_nettype wire

// ===== pin_share_pkg.sv
`default_nettype none
package pin_share_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PIN_N = 6;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] REG_MODE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_FUNC = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PORT_OUT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PORT_DIR = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PORT_IN = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SEL = 4'h5;

  // ==========================================================
  // field positions
  localparam int MODE_EXT_BUS_BIT = 0;
  localparam int FUNC_HOLD_BIT = 0;
  localparam int FUNC_READY_BIT = 1;
  localparam int FUNC_CLK_BIT = 2;
  localparam int FUNC_TX_BIT = 3;
  localparam int SEL_HOLD_BIT = 0;
  localparam int SEL_READY_BIT = 1;
  localparam int SEL_CLK_BIT = 2;
  localparam int SEL_TX_BIT = 3;

  // pin index within the group
  localparam int PIN_P3B4 = 0;
  localparam int PIN_P3B5 = 1;
  localparam int PIN_P3B6 = 2;
  localparam int PIN_P3B7 = 3;
  localparam int PIN_P4B0 = 4;
  localparam int PIN_P4B1 = 5;

  // ==========================================================
  // values after reset
  localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
  localparam logic [DATA_W-1:0] FUNC_RST = 8'h00;
  localparam logic [PIN_N-1:0] PORT_OUT_RST = 6'h00;
  localparam logic [PIN_N-1:0] PORT_DIR_RST = 6'h00;
  localparam logic [PIN_N-1:0] PIN_SYNC_RST = 6'h3F;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

  // ==========================================================
  // types
  typedef logic [PIN_N-1:0] pins_t;

  typedef struct packed {
    logic ext_bus;
    logic hold_en;
    logic ready_en;
    logic clk_en;
    logic tx_en;
  } ctrl_s;

  typedef struct packed {
    logic hold;
    logic ready;
    logic clk;
    logic tx;
  } sel_s;

endpackage
`default_nettype wire

// ===== pin_sync.sv
`default_nettype none
// two-stage synchroniser for the pin group
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pin_share_pkg::pins_t async_i,
  output var pin_share_pkg::pins_t sync_o
);

  pin_share_pkg::pins_t meta;

  // ==========================================================
  // first stage is read only by the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= pin_share_pkg::PIN_SYNC_RST;
      sync_o <= pin_share_pkg::PIN_SYNC_RST;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// ===== pin_share_monitor.sv
`default_nettype none
module pin_share_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [pin_share_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pin_share_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire pin_share_pkg::pins_t pin_in_i,
  input wire pin_share_pkg::pins_t pin_out_o,
  input wire pin_share_pkg::pins_t pin_oe_o,
  input wire logic hold_acknowledge_out_i,
  input wire logic hold_request_in_o,
  input wire logic ext_ready_o,
  input wire logic serial_port_zero_tx_data_i,
  input wire logic serial_port_zero_rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // shadow settings
  logic ext;
  logic [3:0] fn;
  pin_share_pkg::pins_t po;
  pin_share_pkg::pins_t pd;
  logic hs;
  logic rs;
  logic cs;
  // selection decode, rebuilt from bus writes only
  assign hs = ext | fn[0];
  assign rs = ext & fn[1];
  assign cs = ext & fn[2];
  // track writes so the checker never peeks inside
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext <= 1'b0;
      fn <= 4'h0;
      po <= 6'h00;
      pd <= 6'h00;
    end else if (wr_i) begin
      if (addr_i == pin_share_pkg::REG_MODE) ext <= wdata_i[0];
      if (addr_i == pin_share_pkg::REG_FUNC) fn <= wdata_i[3:0];
      if (addr_i == pin_share_pkg::REG_PORT_OUT) po <= wdata_i[5:0];
      if (addr_i == pin_share_pkg::REG_PORT_DIR) pd <= wdata_i[5:0];
    end
  end
  // ==========================================================
  // assertions
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  hold_pins_a: assert property ($past(hs) |-> pin_oe_o[1:0] == 2'h2
    && pin_out_o[1] == $past(hold_acknowledge_out_i)) else $error("hold pins wrong");
  hold_gpio_a: assert property (!$past(hs) |-> pin_oe_o[1:0] == $past(pd[1:0])
    && pin_out_o[1:0] == $past(po[1:0])) else $error("hold pins not port");
  hold_req_a: assert property (hs && $past(hs) && $past(hs, 2)
    |-> hold_request_in_o == $past(pin_in_i[0], 3)) else $error("hold request level");
  ready_pin_a: assert property (pin_oe_o[2] == (!$past(rs) && $past(pd[2])))
    else $error("ready pin enable");
  ready_in_a: assert property (rs && $past(rs) && $past(rs, 2)
    |-> ext_ready_o == $past(pin_in_i[2], 3)) else $error("ready level");
  bus_clk_a: assert property (cs && $past(cs) && $past(cs, 2) && $past(cs, 3)
    |-> pin_oe_o[3] && pin_out_o[3] != $past(pin_out_o[3])) else $error("bus clock");
  clk_gpio_a: assert property (!$past(cs) |-> pin_oe_o[3] == $past(pd[3])
    && pin_out_o[3] == $past(po[3])) else $error("clock pin not port");
  rx_follow_a: assert property ($past(rst_n_i, 3) |-> pin_oe_o[4] == $past(pd[4])
    && serial_port_zero_rx_data_o == $past(pin_in_i[4], 3)) else $error("receive pin");
  tx_pin_a: assert property (pin_oe_o[5] == ($past(fn[3]) || $past(pd[5]))
    && pin_out_o[5] == ($past(fn[3]) ? $past(serial_port_zero_tx_data_i) : $past(po[5])))
    else $error("transmit pin");
  cover property (hs && rs);
  cover property (cs && $past(cs, 4));
  cover property (fn[3] && serial_port_zero_tx_data_i);
endmodule
bind pin_share pin_share_monitor u_pin_share_monitor (.clk_i, .rst_n_i, .addr_i, .wdata_i,
  .wr_i, .pin_in_i, .pin_out_o, .pin_oe_o, .hold_acknowledge_out_i, .hold_request_in_o,
  .ext_ready_o, .serial_port_zero_tx_data_i, .serial_port_zero_rx_data_o);
`default_nettype wire

// ===== pin_peer.sv
`default_nettype none
// far-side agents sharing the pins
module pin_peer (
  input wire logic clk_i,
  input wire pin_share_pkg::pins_t out_i,
  input wire pin_share_pkg::pins_t oe_i,
  input wire pin_share_pkg::pins_t drv_i,
  input wire pin_share_pkg::pins_t drv_en_i,
  output pin_share_pkg::pins_t pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a known start level, so a floating pin never locks at unknown
  pin_share_pkg::pins_t last = 6'h00;
  // receive pin yields
  // floating pins invert, so a stale level never passes
  assign pin_o = (oe_i & out_i) | (~oe_i & drv_en_i & drv_i) | (~oe_i & ~drv_en_i & ~last);
  // remember the wire for the floating case
  always_ff @(posedge clk_i) begin
    last <= pin_o;
  end
endmodule
`default_nettype wire

// ===== pin_share_tb_top.sv
`default_nettype none
module pin_share_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  pin_share_pkg::pins_t pin_in_i;
  pin_share_pkg::pins_t pin_out_o;
  pin_share_pkg::pins_t pin_oe_o;
  pin_share_pkg::pins_t drv = 6'h00;
  pin_share_pkg::pins_t drv_en = 6'h00;
  logic hold_acknowledge_out_i = 1'b0;
  logic serial_port_zero_tx_data_i = 1'b0;
  logic hold_request_in_o;
  logic ext_ready_o;
  logic serial_port_zero_rx_data_o;
  logic ext_bus_mode_o;
  int mismatches = 0;
  int total_checks = 0;
  // ==========================================================
  // plumbing
  pin_share u_pin_share (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .pin_in_i, .pin_out_o, .pin_oe_o, .hold_acknowledge_out_i, .hold_request_in_o,
    .ext_ready_o, .serial_port_zero_tx_data_i, .serial_port_zero_rx_data_o, .ext_bus_mode_o);
  pin_peer u_pin_peer (.clk_i, .out_i(pin_out_o), .oe_i(pin_oe_o), .drv_i(drv),
    .drv_en_i(drv_en), .pin_o(pin_in_i));
  always #20 clk_i = ~clk_i;
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, e);
  endtask
  // two sync edges plus the output flop, two edges to spare
  task automatic settle();
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk({4'h0, hold_request_in_o, ext_ready_o, serial_port_zero_rx_data_o, ext_bus_mode_o}, 8'h06);
    chk({2'h0, pin_oe_o}, 8'h00);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic t_regs();
    wr(pin_share_pkg::REG_MODE, 8'hFF);
    rd(pin_share_pkg::REG_MODE, 8'h01);
    wr(pin_share_pkg::REG_FUNC, 8'hFF);
    rd(pin_share_pkg::REG_FUNC, 8'h0F);
    wr(pin_share_pkg::REG_SEL, 8'h00);
    rd(pin_share_pkg::REG_SEL, 8'h0F);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
  endtask
  // every mode and enable mix, port bits high so dedicated pins show
  task automatic t_modes();
    logic [4:0] v;
    logic h;
    logic r;
    logic k;
    wr(pin_share_pkg::REG_PORT_OUT, 8'h3F);
    wr(pin_share_pkg::REG_PORT_DIR, 8'h2F);
    for (int c = 0; c < 32; c++) begin
      v = c[4:0];
      h = v[4] | v[0];
      r = v[4] & v[1];
      k = v[4] & v[2];
      wr(pin_share_pkg::REG_MODE, {7'h00, v[4]});
      wr(pin_share_pkg::REG_FUNC, {4'h0, v[3:0]});
      hold_acknowledge_out_i <= v[0];
      serial_port_zero_tx_data_i <= v[1];
      rd(pin_share_pkg::REG_SEL, {4'h0, v[3], k, r, h});
      chk({ext_bus_mode_o, 1'b0, pin_oe_o}, {v[4], 4'h5, ~r, 1'b1, ~h});
      chk({2'h0, pin_out_o & 6'h37}, {2'h0, v[3] ? v[1] : 1'b1, 2'h2, ~r,
        h ? v[0] : 1'b1, ~h});
    end
  endtask
  task automatic t_inputs();
    wr(pin_share_pkg::REG_MODE, 8'h01);
    wr(pin_share_pkg::REG_FUNC, 8'h03);
    drv_en <= 6'h15;
    drv <= 6'h01;
    settle();
    chk({5'h00, hold_request_in_o, ext_ready_o, serial_port_zero_rx_data_o}, 8'h04);
    drv <= 6'h14;
    settle();
    chk({5'h00, hold_request_in_o, ext_ready_o, serial_port_zero_rx_data_o}, 8'h03);
    wr(pin_share_pkg::REG_PORT_DIR, 8'h00);
    wr(pin_share_pkg::REG_MODE, 8'h00);
    wr(pin_share_pkg::REG_FUNC, 8'h00);
    drv_en <= 6'h3F;
    drv <= 6'h21;
    settle();
    chk({5'h00, hold_request_in_o, ext_ready_o, serial_port_zero_rx_data_o}, 8'h02);
    rd(pin_share_pkg::REG_PORT_IN, 8'h21);
  endtask
  // bus clock pin driven and toggling once selected
  task automatic t_clock();
    logic first;
    wr(pin_share_pkg::REG_MODE, 8'h01);
    wr(pin_share_pkg::REG_FUNC, 8'h04);
    settle();
    first = pin_out_o[3];
    @(negedge clk_i);
    chk({7'h00, pin_oe_o[3]}, 8'h01);
    chk({7'h00, pin_out_o[3]}, {7'h00, ~first});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_regs();
    t_modes();
    t_inputs();
    t_clock();
    t_reset();
    rd(pin_share_pkg::REG_FUNC, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
